// ### common/hmbg_pkg.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// shared constants of the hub management bus glue
package hmbg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clocking
  localparam int unsigned REF_CLK_HZ    = 20_000_000;               // ref_clk rate
  localparam int unsigned TX_CLK_HZ     = 10_000_000;               // transmit clock rate
  localparam int unsigned TX_TOGGLE_CYC = REF_CLK_HZ / (2 * TX_CLK_HZ); // edges per half period

  ////////////////////////////////////////////////////////////////////////////
  // apb register map (byte addresses)
  localparam int unsigned ADDR_W        = 8;                        // decoded address bits
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;                    // control, read/write
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;                    // live pin levels, read only
  localparam logic [7:0]  ADDR_IRQ_STAT = 8'h08;                    // sticky events, read only
  localparam logic [7:0]  ADDR_IRQ_EN   = 8'h0c;                    // event enables, read/write
  localparam logic [7:0]  ADDR_IRQ_CLR  = 8'h10;                    // write one to clear

  ////////////////////////////////////////////////////////////////////////////
  // control fields
  localparam int unsigned CTRL_EXT_BIT  = 0;                        // external codec select
  localparam logic        CTRL_EXT_RST  = 1'b0;                     // internal codec after reset

  ////////////////////////////////////////////////////////////////////////////
  // status fields
  localparam int unsigned ST_GRANT_IN   = 0;
  localparam int unsigned ST_TX_EN      = 1;
  localparam int unsigned ST_COL_SENSE  = 2;
  localparam int unsigned ST_NET_COL    = 3;
  localparam int unsigned ST_PACKET_COMPRESS_OUT      = 4;
  localparam int unsigned ST_GRANT_OUT  = 5;
  localparam int unsigned ST_COL_MAC    = 6;
  localparam int unsigned ST_TXCLK      = 7;
  localparam int unsigned ST_W          = 8;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt event fields
  localparam int unsigned IRQ_COL_MAC   = 0;                        // collision to controller
  localparam int unsigned IRQ_COL_DRV   = 1;                        // collision driven on bus
  localparam int unsigned IRQ_PACKET_COMPRESS_OUT     = 2;                        // packet compression
  localparam int unsigned IRQ_W         = 3;
  localparam logic [2:0]  IRQ_EN_RST    = 3'h0;
  localparam logic [2:0]  IRQ_STAT_RST  = 3'h0;

endpackage : hmbg_pkg
`default_nettype wire

// ### hdl/hmbg_arb_glue.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// combinational arbitration and collision glue, no storage at all
module hmbg_arb_glue (
  input  wire logic mac_tx_enable,         // controller wants to transmit
  input  wire logic arb_grant_in,          // permission from upstream
  input  wire logic external_codec_select, // external codec mode
  input  wire logic collision_sense,       // bus collision seen by transceiver
  input  wire logic network_rx_collision,  // receive collision on the network
  output logic      arb_grant_out,         // permission to downstream
  output logic      bus_tx_enable,         // transceiver transmit drive enable
  output logic      activity_drive,        // tell repeaters we transmit
  output logic      collision_drive,       // flag bus collision
  output logic      collision_to_mac       // collision to controller
);

  // pass the grant only when we do not want it ourselves
  assign arb_grant_out    = arb_grant_in & ~mac_tx_enable;                       // RQ3 RQ4 RQ5
  // drive the bus only with permission and in external codec mode
  assign bus_tx_enable    = mac_tx_enable & arb_grant_in & external_codec_select; // RQ6
  // activity means transmit with permission
  assign activity_drive   = mac_tx_enable & arb_grant_in;                        // RQ7
  // transmitting without permission is a collision
  assign collision_drive  = mac_tx_enable & ~arb_grant_in;                       // RQ8
  // any sensed collision while transmitting reaches the controller
  assign collision_to_mac = mac_tx_enable & (collision_sense | network_rx_collision); // RQ9 RQ10

endmodule : hmbg_arb_glue
`default_nettype wire

// ### hdl/hmbg_txclk_div.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// halves ref_clk into the transmit clock, driven only in external codec mode
module hmbg_txclk_div (
  input  wire logic ref_clk,               // 20 MHz
  input  wire logic resetn,                // async, active low
  input  wire logic external_codec_select, // 1: we own the clock node
  output logic      tx_clock_10m,          // divided clock
  output logic      tx_clock_oe_n          // low while we drive the node
);

  logic tx_clk_r;                          // toggle flop
  logic tx_clk_nxt;                        // its next value

  // own value inverted gives half the reference rate
  assign tx_clk_nxt = ~tx_clk_r;           // RQ2 RQ11

  // toggle flop, starts low so the first edge gives a clean high
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_clk_r <= 1'b0;                    // RQ16
    end else begin
      tx_clk_r <= tx_clk_nxt;
    end
  end

  assign tx_clock_10m  = tx_clk_r;
  // release the node in internal mode, the controller drives it then
  assign tx_clock_oe_n = ~external_codec_select; // RQ13 RQ14

endmodule : hmbg_txclk_div
`default_nettype wire

// ### hdl/hmbg_top.sv
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// RQ1: compression output passes straight to the bus
// RQ2: transmit clock runs at 10 MHz
// RQ3: incoming grant high means permission, low denial
// RQ4: grant out high only when granted, idle
// RQ5: grant out low when denied or transmitting
// RQ6: drive enable needs transmit, grant, external codec
// RQ7: activity when transmitting with grant
// RQ8: collision drive when transmitting without grant
// RQ9: sensed bus collision feeds collision output
// RQ10: collision out when transmitting and any collision
// RQ11: transmit clock toggles every rising reference clock edge
// RQ12: glue outputs purely combinational, no register
// RQ13: transmit clock driven only in external mode
// RQ14: internal codec mode leaves clock node undriven
// RQ15: codec select low internal, high external
// RQ16: transmit clock flop resets low
////////////////////////////////////////////////////////////////////////////////
module hmbg_top
  import hmbg_pkg::*;
(
  input  wire logic        ref_clk,              // 20 MHz system clock
  input  wire logic        resetn,               // async reset, active low
  // apb slave
  input  wire logic        psel,                 // slave select
  input  wire logic        penable,              // access phase
  input  wire logic        pwrite,               // 1 write, 0 read
  input  wire logic [7:0]  paddr,                // byte address
  input  wire logic [31:0] pwdata,               // write data
  output logic      [31:0] prdata,               // read data
  output logic             pready,               // transfer done
  output logic             pslverr,              // unmapped address
  output logic             irq,                  // level interrupt
  // controller side
  input  wire logic        mac_tx_enable,        // controller transmit enable
  input  wire logic        mac_tx_data,          // controller transmit data
  input  wire logic        mac_packet_compress,  // controller compression pin
  output logic             mac_rx_clock,         // management receive clock to controller
  output logic             collision_to_mac,     // collision to controller
  output logic             external_codec_select,// codec select to controller
  output logic             tx_clock_10m,         // transmit clock node, output
  output logic             tx_clock_oe_n,        // transmit clock node, enable low
  // shared bus side
  input  wire logic        arb_grant_in,         // upstream permission
  input  wire logic        collision_sense,      // transceiver collision sense
  input  wire logic        network_rx_collision, // network receive collision
  input  wire logic        mgmt_rx_clock,        // management receive clock from bus
  output logic             arb_grant_out,        // downstream permission
  output logic             bus_tx_enable,        // transceiver drive enable
  output logic             bus_tx_data,          // transmit data to bus
  output logic             activity_drive,       // activity to repeaters
  output logic             collision_drive,      // collision to repeaters
  output logic             packet_compress_out   // compression to bus
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic             ext_r;           // codec select register
  logic             ext_nxt;
  logic [2:0]       irq_en_r;        // event enables
  logic [2:0]       irq_en_nxt;
  logic [2:0]       irq_stat_r;      // sticky events
  logic [2:0]       irq_stat_nxt;
  logic [2:0]       ev_prev_r;       // event levels one cycle ago
  logic [2:0]       ev_now;          // event levels now
  logic [2:0]       ev_rise;         // rising edges of events
  logic [2:0]       clr_mask;        // bits software clears
  logic             irq_r;           // interrupt flop
  logic [31:0]      prdata_r;        // read data flop
  logic [31:0]      prdata_nxt;
  logic             pready_r;        // ready flop
  logic             pslverr_r;       // error flop
  logic             setup_ph;        // apb setup cycle
  logic             access_done;     // access completes this edge
  logic             wr_done;         // write takes effect
  logic             hit_ctrl;        // address decodes
  logic             hit_status;
  logic             hit_stat;
  logic             hit_en;
  logic             hit_clr;
  logic             hit_any;
  logic [ST_W-1:0]  status_vec;      // live levels
  logic             col_mac_w;       // glue results
  logic             col_drv_w;

  ////////////////////////////////////////////////////////////////////////////
  // combinational glue
  hmbg_arb_glue u_glue (
    .mac_tx_enable         (mac_tx_enable),
    .arb_grant_in          (arb_grant_in),
    .external_codec_select (ext_r),
    .collision_sense       (collision_sense),
    .network_rx_collision  (network_rx_collision),
    .arb_grant_out         (arb_grant_out),
    .bus_tx_enable         (bus_tx_enable),
    .activity_drive        (activity_drive),
    .collision_drive       (col_drv_w),
    .collision_to_mac      (col_mac_w)
  );

  assign collision_drive  = col_drv_w;   // RQ12
  assign collision_to_mac = col_mac_w;   // RQ12
  // compression is forwarded, the transmitting repeater stops the clock
  assign packet_compress_out = mac_packet_compress; // RQ1
  // receive clock and transmit data pass through unchanged
  assign mac_rx_clock = mgmt_rx_clock;
  assign bus_tx_data  = mac_tx_data;

  ////////////////////////////////////////////////////////////////////////////
  // transmit clock divider
  hmbg_txclk_div u_div (
    .ref_clk               (ref_clk),
    .resetn                (resetn),
    .external_codec_select (ext_r),
    .tx_clock_10m          (tx_clock_10m),
    .tx_clock_oe_n         (tx_clock_oe_n)
  );

  // select straight from its register
  assign external_codec_select = ext_r;  // RQ15

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  assign setup_ph    = psel & ~penable;
  assign access_done = psel & penable & pready_r;
  assign wr_done     = access_done & pwrite & ~pslverr_r;
  assign hit_ctrl    = (paddr == ADDR_CTRL);
  assign hit_status  = (paddr == ADDR_STATUS);
  assign hit_stat    = (paddr == ADDR_IRQ_STAT);
  assign hit_en      = (paddr == ADDR_IRQ_EN);
  assign hit_clr     = (paddr == ADDR_IRQ_CLR);
  assign hit_any     = hit_ctrl | hit_status | hit_stat | hit_en | hit_clr;

  // live levels for software
  assign status_vec = {tx_clock_10m, col_mac_w, arb_grant_out, mac_packet_compress,
                       network_rx_collision, collision_sense, mac_tx_enable, arb_grant_in};

  // read mux, unmapped and write-only read as zero
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    if (hit_ctrl) begin
      prdata_nxt[CTRL_EXT_BIT] = ext_r;
    end else if (hit_status) begin
      prdata_nxt[ST_W-1:0] = status_vec;
    end else if (hit_stat) begin
      prdata_nxt[IRQ_W-1:0] = irq_stat_r;
    end else if (hit_en) begin
      prdata_nxt[IRQ_W-1:0] = irq_en_r;
    end else begin
      prdata_nxt = 32'h0000_0000;
    end
  end

  // answer is prepared in the setup cycle, ready in the first access cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= setup_ph;
      pslverr_r <= setup_ph & ~hit_any;
      prdata_r  <= (setup_ph & ~pwrite) ? prdata_nxt : prdata_r;
    end
  end

  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign prdata  = prdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  assign ext_nxt    = (wr_done & hit_ctrl) ? pwdata[CTRL_EXT_BIT] : ext_r;  // RQ15
  assign irq_en_nxt = (wr_done & hit_en) ? pwdata[IRQ_W-1:0] : irq_en_r;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ext_r    <= CTRL_EXT_RST;
      irq_en_r <= IRQ_EN_RST;
    end else begin
      ext_r    <= ext_nxt;
      irq_en_r <= irq_en_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt events, set wins over clear
  assign ev_now       = {mac_packet_compress, col_drv_w, col_mac_w};
  assign ev_rise      = ev_now & ~ev_prev_r;
  assign clr_mask     = (wr_done & hit_clr) ? pwdata[IRQ_W-1:0] : 3'h0;
  assign irq_stat_nxt = (irq_stat_r & ~clr_mask) | ev_rise;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ev_prev_r  <= 3'h0;
      irq_stat_r <= IRQ_STAT_RST;
      irq_r      <= 1'b0;
    end else begin
      ev_prev_r  <= ev_now;
      irq_stat_r <= irq_stat_nxt;
      irq_r      <= |(irq_stat_nxt & irq_en_nxt);
    end
  end

  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_packet_compress_out;
    @(posedge ref_clk) disable iff (!resetn)
      packet_compress_out == mac_packet_compress;
  endproperty
  a_packet_compress_out: assert property (p_packet_compress_out) else $error("compression not forwarded"); // RQ1

  property p_txclk_toggle;
    @(posedge ref_clk) disable iff (!resetn)
      $past(resetn) |-> (tx_clock_10m != $past(tx_clock_10m));
  endproperty
  a_txclk_toggle: assert property (p_txclk_toggle) else $error("clock not halved"); // RQ2 RQ11

  property p_grant_pass;
    @(posedge ref_clk) disable iff (!resetn)
      (arb_grant_in && !mac_tx_enable) |-> arb_grant_out;
  endproperty
  a_grant_pass: assert property (p_grant_pass) else $error("grant not passed"); // RQ3 RQ4

  property p_grant_deny;
    @(posedge ref_clk) disable iff (!resetn)
      (!arb_grant_in || mac_tx_enable) |-> !arb_grant_out;
  endproperty
  a_grant_deny: assert property (p_grant_deny) else $error("grant leaked"); // RQ5

  property p_drive_en;
    @(posedge ref_clk) disable iff (!resetn)
      bus_tx_enable == (mac_tx_enable && arb_grant_in && external_codec_select);
  endproperty
  a_drive_en: assert property (p_drive_en) else $error("drive enable wrong"); // RQ6

  property p_activity;
    @(posedge ref_clk) disable iff (!resetn)
      activity_drive |-> (mac_tx_enable && arb_grant_in && !collision_drive);
  endproperty
  a_activity: assert property (p_activity) else $error("activity wrong"); // RQ7

  property p_col_drive;
    @(posedge ref_clk) disable iff (!resetn)
      (mac_tx_enable && !arb_grant_in) |-> (collision_drive && !activity_drive);
  endproperty
  a_col_drive: assert property (p_col_drive) else $error("collision drive wrong"); // RQ8

  property p_col_mac;
    @(posedge ref_clk) disable iff (!resetn)
      collision_to_mac == (mac_tx_enable && (collision_sense || network_rx_collision));
  endproperty
  a_col_mac: assert property (p_col_mac) else $error("collision out wrong"); // RQ9 RQ10

  property p_clk_oe;
    @(posedge ref_clk) disable iff (!resetn)
      (wr_done && hit_ctrl) |=> (tx_clock_oe_n == !$past(pwdata[CTRL_EXT_BIT]));
  endproperty
  a_clk_oe: assert property (p_clk_oe) else $error("clock enable wrong"); // RQ13 RQ14 RQ15

  property p_irq_sticky;
    @(posedge ref_clk) disable iff (!resetn)
      (irq_stat_r[IRQ_COL_MAC] && !(wr_done && hit_clr)) |=> irq_stat_r[IRQ_COL_MAC];
  endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("event lost");

endmodule : hmbg_top
`default_nettype wire

// ### sim/hmbg_rep_model.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// stand-in for the repeater chain: grant, collision lines, receive clock
module hmbg_rep_model (
  input  wire logic ref_clk,              // reference clock
  input  wire logic packet_compress_out,  // compression request from the block
  input  wire logic grant_set,            // bench control of the grant
  input  wire logic col_set,              // bench control of bus collision
  input  wire logic ncol_set,             // bench control of network collision
  output logic      arb_grant_in,         // upstream permission
  output logic      collision_sense,      // sensed bus collision
  output logic      network_rx_collision, // network receive collision
  output logic      mgmt_rx_clock         // management receive clock
);
  // grant high permits, low denies
  assign arb_grant_in         = grant_set;
  // sensed collisions reported to the glue
  assign collision_sense      = col_set;
  assign network_rx_collision = ncol_set;
  initial mgmt_rx_clock = 1'b0;
  // receive clock is held low while compression is asked for
  always @(posedge ref_clk) begin
    if (packet_compress_out === 1'b1) mgmt_rx_clock <= 1'b0;
    else mgmt_rx_clock <= ~mgmt_rx_clock;
  end
endmodule : hmbg_rep_model
`default_nettype wire

// ### sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// self-checking bench: apb master, glue stimulus, queue scoreboard
module testbench;
  import hmbg_pkg::*;
  logic        ref_clk, resetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, irq, mac_tx_enable, mac_tx_data, mac_packet_compress;
  logic        mac_rx_clock, collision_to_mac, external_codec_select, tx_clock_10m;
  logic        tx_clock_oe_n, arb_grant_in, collision_sense, network_rx_collision;
  logic        mgmt_rx_clock, arb_grant_out, bus_tx_enable, bus_tx_data;
  logic        activity_drive, collision_drive, packet_compress_out;
  logic        grant_set, col_set, ncol_set, g_req, ck_on, ck_prev, ext_b;
  logic [7:0]  gq[$];  // expected glue outputs
  logic [33:0] aq[$];  // expected {is read, slverr, data}
  logic [7:0]  e;
  logic [33:0] a;
  int          n_errors, n_checks, cyc;

  hmbg_top hmbg_top_inst (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .mac_tx_enable(mac_tx_enable), .mac_tx_data(mac_tx_data),
    .mac_packet_compress(mac_packet_compress), .mac_rx_clock(mac_rx_clock),
    .collision_to_mac(collision_to_mac), .external_codec_select(external_codec_select),
    .tx_clock_10m(tx_clock_10m), .tx_clock_oe_n(tx_clock_oe_n), .arb_grant_in(arb_grant_in),
    .collision_sense(collision_sense), .network_rx_collision(network_rx_collision),
    .mgmt_rx_clock(mgmt_rx_clock), .arb_grant_out(arb_grant_out),
    .bus_tx_enable(bus_tx_enable), .bus_tx_data(bus_tx_data),
    .activity_drive(activity_drive), .collision_drive(collision_drive),
    .packet_compress_out(packet_compress_out));
  hmbg_rep_model hmbg_rep_model_inst (.ref_clk(ref_clk),
    .packet_compress_out(packet_compress_out), .grant_set(grant_set), .col_set(col_set),
    .ncol_set(ncol_set), .arb_grant_in(arb_grant_in), .collision_sense(collision_sense),
    .network_rx_collision(network_rx_collision), .mgmt_rx_clock(mgmt_rx_clock));

  ////////////////////////////////////////////////////////////////////////////////
  // 20 MHz clock and hang guard
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      end_sim();
    end
  end

  // compare a single bit or a word
  task automatic cmp_bit(input logic got, input logic exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %b want %b", $time, m, got, exp);
    end
  endtask : cmp_bit
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask : cmp_word

  // apb transfer: setup, access, hold until pready
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d, input logic err);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= wr ? d : 32'h0;
    aq.push_back({~wr, err, d});
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // drive glue inputs and note the expected outputs
  task automatic glue(input logic tx, g, cs, nc, d, pc);
    @(posedge ref_clk);
    mac_tx_enable       <= tx;
    grant_set           <= g;
    col_set             <= cs;
    ncol_set            <= nc;
    mac_tx_data         <= d;
    mac_packet_compress <= pc;
    gq.push_back({g & ~tx, tx & g & ext_b, tx & g, tx & ~g, tx & (cs | nc), pc, d, ~ext_b});
    g_req <= 1'b1;
    @(posedge ref_clk);
    g_req <= 1'b0;
  endtask : glue

  // verdict
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////////
  // watcher: takes the oldest note when a result shows
  always @(negedge ref_clk) begin
    if (g_req === 1'b1) begin
      e = gq.pop_front();
      cmp_bit(arb_grant_out, e[7], "grant out");
      cmp_bit(bus_tx_enable, e[6], "drive enable");
      cmp_bit(activity_drive, e[5], "activity");
      cmp_bit(collision_drive, e[4], "collision drive");
      cmp_bit(collision_to_mac, e[3], "collision out");
      cmp_bit(packet_compress_out, e[2], "compress");
      cmp_bit(bus_tx_data, e[1], "tx data");
      cmp_bit(tx_clock_oe_n, e[0], "clock enable");
      cmp_bit(external_codec_select, ~e[0], "codec select");
    end
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      a = aq.pop_front();
      cmp_bit(pslverr, a[32], "slverr");
      if (a[33]) cmp_word(prdata, a[31:0], "read data");
    end
    if (ck_on === 1'b1) cmp_bit(tx_clock_10m, ~ck_prev, "clock toggle");
    ck_prev = tx_clock_10m;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {ref_clk, resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {mac_tx_enable, mac_tx_data, mac_packet_compress, grant_set, col_set, ncol_set} = '0;
    {g_req, ck_on, ck_prev, ext_b} = '0;
    void'($urandom(32'h7297));
    #60;
    cmp_bit(tx_clock_10m, 1'b0, "clock in reset");
    cmp_bit(tx_clock_oe_n, 1'b1, "enable in reset");
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    #1 cmp_bit(tx_clock_10m, 1'b1, "first clock edge");
    // register reset values and access kinds
    apb(0, ADDR_CTRL, 32'h0, 0);
    apb(0, ADDR_IRQ_EN, 32'h0, 0);
    apb(0, ADDR_IRQ_STAT, 32'h0, 0);
    apb(1, ADDR_IRQ_STAT, 32'hff, 0);
    apb(0, ADDR_IRQ_STAT, 32'h0, 0);
    apb(1, ADDR_IRQ_EN, 32'h7, 0);
    apb(0, ADDR_IRQ_EN, 32'h7, 0);
    apb(0, ADDR_IRQ_CLR, 32'h0, 0);
    apb(1, ADDR_STATUS, 32'hff, 0);
    apb(0, ADDR_CTRL, 32'h0, 0);
    apb(1, 8'h40, 32'h1, 1);
    apb(0, 8'h40, 32'h0, 1);
    apb(1, ADDR_IRQ_EN, 32'h0, 0);
    $display("test registers done");
    // every glue input combination in both codec modes
    for (int x = 0; x < 2; x++) begin
      apb(1, ADDR_CTRL, 32'(x), 0);
      ext_b = x[0];
      for (int i = 0; i < 16; i++) glue(i[0], i[1], i[2], i[3], 1'($urandom), 1'($urandom));
    end
    $display("test glue done");
    // divided clock in external mode, released in internal mode
    ck_on <= 1'b1;
    repeat (8) @(posedge ref_clk);
    ck_on <= 1'b0;
    apb(1, ADDR_CTRL, 32'h0, 0);
    ext_b = 1'b0;
    @(negedge ref_clk);
    cmp_bit(tx_clock_oe_n, 1'b1, "internal mode");
    $display("test clock done");
    // interrupt raise, mask, clear
    glue(0, 1, 0, 0, 0, 0);
    apb(1, ADDR_IRQ_CLR, 32'h7, 0);
    apb(1, ADDR_IRQ_EN, 32'h1, 0);
    glue(1, 1, 1, 0, 0, 0);
    repeat (2) @(negedge ref_clk);
    cmp_bit(irq, 1'b1, "irq raised");
    apb(0, ADDR_IRQ_STAT, 32'h1, 0);
    apb(1, ADDR_IRQ_EN, 32'h0, 0);
    repeat (2) @(negedge ref_clk);
    cmp_bit(irq, 1'b0, "irq masked");
    apb(1, ADDR_IRQ_EN, 32'h1, 0);
    glue(0, 1, 0, 0, 0, 0);
    apb(1, ADDR_IRQ_CLR, 32'h1, 0);
    repeat (2) @(negedge ref_clk);
    cmp_bit(irq, 1'b0, "irq cleared");
    apb(0, ADDR_IRQ_STAT, 32'h0, 0);
    $display("test interrupt done");
    // receive clock runs without compression
    @(negedge ref_clk);
    e[0] = mac_rx_clock;
    @(negedge ref_clk);
    cmp_bit(mac_rx_clock, ~e[0], "receive clock runs");
    // compression halts the receive clock
    glue(0, 1, 0, 0, 0, 1);
    repeat (3) begin
      @(negedge ref_clk);
      cmp_bit(mac_rx_clock, 1'b0, "receive clock held");
    end
    // compression and bus collision events are sticky but masked
    apb(0, ADDR_IRQ_STAT, 32'h4, 0);
    glue(1, 0, 0, 0, 0, 1);
    apb(0, ADDR_IRQ_STAT, 32'h6, 0);
    cmp_bit(irq, 1'b0, "irq ignores masked events");
    $display("test compression done");
    // random traffic
    repeat (20) glue(1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom),
                     1'($urandom), 1'($urandom));
    $display("test random done");
    end_sim();
  end
endmodule : testbench
`default_nettype wire
